// [hw/ccr_pkg.sv]
/*
 Shared constants of the codec configuration link: command bytes, field
 positions, reset values, writable-bit masks and the controller's APB map.
 Assumes both link ends and the bench import it whole.
*/
package ccr_pkg;

	localparam logic [7:0] CMD_OC = 8'h70;
	localparam logic [7:0] CMD_CC = 8'h46;
	localparam logic [7:0] CMD_OF = 8'h60;
	localparam int         CMD_READ_BIT = 0;

	localparam logic [1:0] SEL_OC   = 2'h0;
	localparam logic [1:0] SEL_CC   = 2'h1;
	localparam logic [1:0] SEL_OF   = 2'h2;
	localparam logic [1:0] SEL_NONE = 2'h3;

	localparam logic [7:0] OC_RESET = 8'h04;
	localparam logic [7:0] CC_RESET = 8'h9A;
	localparam logic [7:0] OF_RESET = 8'h00;
	localparam logic [7:0] OC_MASK  = 8'hFF;
	localparam logic [7:0] CC_MASK  = 8'hC0;
	localparam logic [7:0] OF_MASK  = 8'h7F;

	localparam int OC_TX_CUT = 7;
	localparam int OC_RX_CUT = 6;
	localparam int OC_HPF    = 5;
	localparam int OC_LOSS   = 4;
	localparam int OC_ARM    = 3;
	localparam int OC_ILB    = 2;
	localparam int OC_FDL    = 1;
	localparam int OC_TONE   = 0;
	localparam int CC_IRQ_OD = 7;
	localparam int CC_CHOP   = 6;
	localparam int OF_MULAW  = 6;
	localparam int OF_COEF_HI = 5;

	localparam logic [3:0] CHOP_DIV_SLOW = 4'h8;
	localparam logic [3:0] CHOP_DIV_FAST = 4'h7;
	localparam logic [3:0] CHOP_HIGH_CNT = 4'h4;

	localparam logic [7:0] APB_CMD    = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam int CMDF_SEL_LO  = 8;
	localparam int CMDF_WRITE   = 12;
	localparam int STF_BUSY     = 0;
	localparam int STF_DONE     = 1;
	localparam int STF_RDATA_LO = 8;

	function automatic logic [1:0] ccr_cmd_sel(input logic [7:0] b);
		if (b[7:1] == CMD_OC[7:1])
			return SEL_OC;
		else if (b[7:1] == CMD_CC[7:1])
			return SEL_CC;
		else if (b[7:1] == CMD_OF[7:1])
			return SEL_OF;
		return SEL_NONE;
	endfunction

	function automatic logic [7:0] ccr_mask(input logic [1:0] s);
		case (s)
			SEL_OC: return OC_MASK;
			SEL_CC: return CC_MASK;
			SEL_OF: return OF_MASK;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] ccr_cmd_byte(input logic [1:0] s);
		case (s)
			SEL_CC: return CMD_CC;
			SEL_OF: return CMD_OF;
			default: return CMD_OC;
		endcase
	endfunction

endpackage

// [hw/ccr_link_if.sv]
/*
 Monitor-channel byte link between the line card controller and the codec.
 Assumes both ends run on the same core_clk; each cycle with a valid high carries one byte.
*/
`timescale 1ns/10ps
`default_nettype none
interface ccr_link_if;
	logic       dnValid;
	logic [7:0] dnByte;
	logic       upValid;
	logic [7:0] upByte;
	modport dev (input dnValid, input dnByte, output upValid, output upByte);
	modport ctl (output dnValid, output dnByte, input upValid, input upByte);
endinterface
`default_nettype wire

// [hw/ccr_dev_end.sv]
/*
 Codec end: the three configuration registers, their command decoder on the
 monitor channel and the logic the register bits steer directly.
 Assumes refTick is a one-cycle 2048 kHz pulse and txIrqEvent a level, both
 from core_clk logic, so neither needs a synchroniser.
 Assumes the far end always sends a data byte straight after a write
 command; a lost data byte would leave the decoder waiting for it.
*/
// The implementer's own choices: the register offsets and the APB interface to the registers.
// Behaviour
// RL1 - 70h writes, 71h reads operating conditions
// RL2 - Transmit cutoff bit disconnects transmit path
// RL3 - Receive cutoff cuts receive, disables B filter
// RL4 - High-pass bit disables transmit high-pass filter
// RL5 - Loss bit inserts fixed receive loss
// RL6 - Arm bit arms transmit interrupt
// RL7 - Interface loopback bit enables interface loopback
// RL8 - Full digital loopback bit enables loopback
// RL9 - Tone bit injects 1 kHz receive tone
// RL10 - 46h/47h access chip configuration, low reserved
// RL11 - Bit 7 chooses driven or open-drain interrupt
// RL12 - Bit 6 chooses chopper divide eight or seven
// RL13 - Controller writes reserved bits as zero
// RL14 - 60h/61h access operating functions, bit7 reserved
// RL15 - Bit 6 chooses A-law or mu-law
// RL16 - Low six bits pick programmed filter coefficients
// RL17 - Reads answer upstream, writes apply after data

`timescale 1ns/10ps
`default_nettype none
module ccr_dev_end
	import ccr_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       srst,
	ccr_link_if.dev         link,
	input  wire logic       refTick,
	input  wire logic       txIrqEvent,
	output logic            txPathCutoff,
	output logic            rxPathCutoff,
	output logic            bFilterDisable,
	output logic            txHighpassDisable,
	output logic            rxLossInsert,
	output logic            txInterruptArm,
	output logic            interfaceLoopback,
	output logic            fullDigitalLoopback,
	output logic            rxTestTone,
	output logic            muLawSelect,
	output logic [5:0]      filterCoefSel,
	output logic            chopperClk,
	output logic            irqNOut,
	output logic            irqNOeN
);

	// One-hot states keep each state test to a single bit.
	typedef enum logic [1:0] {
		DS_IDLE = 2'b01,
		DS_DATA = 2'b10
	} ccr_dev_fsm_t;

	// Every flop of the block lives in this record, so reset covers all.
	typedef struct packed {
		ccr_dev_fsm_t fsm;
		logic [1:0]   sel;
		logic [7:0]   oc;
		logic [7:0]   cc;
		logic [7:0]   fn;
		logic         upValid;
		logic [7:0]   upByte;
		logic [3:0]   chopCnt;
		logic         chopClk;
		logic         irqN;
		logic         irqOeN;
	} ccr_dev_st_t;

	ccr_dev_st_t st_reg;
	ccr_dev_st_t st_next;
	// Combinational helpers, each set on every pass.
	logic [1:0]  cmdSel;
	logic [7:0]  wrMask;
	logic [3:0]  chopDiv;
	logic        irqActive;

	always_comb begin
		st_next = st_reg;
		st_next.upValid = 1'b0;
		cmdSel = ccr_cmd_sel(link.dnByte);
		wrMask = ccr_mask(st_reg.sel);
		case (st_reg.fsm)
			DS_IDLE: begin
				// Unknown bytes are dropped, so noise opens no data slot.
				// RL1 RL10 RL14 command decode
				if (link.dnValid && cmdSel != SEL_NONE) begin
					if (link.dnByte[CMD_READ_BIT]) begin
						// The answer leaves one cycle after its command.
						// RL17 read answers upstream
						st_next.upValid = 1'b1;
						case (cmdSel)
							SEL_OC: st_next.upByte = st_reg.oc;
							SEL_CC: st_next.upByte = st_reg.cc;
							default: st_next.upByte = st_reg.fn;
						endcase
					end else begin
						st_next.sel = cmdSel;
						st_next.fsm = DS_DATA;
					end
				end
			end
			DS_DATA: begin
				// Reserved bits keep their stored value whatever arrives.
				// RL17 masked write after data
				if (link.dnValid) begin
					case (st_reg.sel)
						SEL_OC: st_next.oc = (st_reg.oc & ~wrMask) |
							(link.dnByte & wrMask);
						SEL_CC: st_next.cc = (st_reg.cc & ~wrMask) |
							(link.dnByte & wrMask);
						default: st_next.fn = (st_reg.fn & ~wrMask) |
							(link.dnByte & wrMask);
					endcase
					st_next.fsm = DS_IDLE;
				end
			end
			// An illegal state falls back to idle.
			default: begin
				st_next.fsm = DS_IDLE;
			end
		endcase

		// A rate change can leave the count past the new end, hence >=.
		// RL12 chopper divide select
		chopDiv = st_reg.cc[CC_CHOP] ? CHOP_DIV_FAST : CHOP_DIV_SLOW;
		if (refTick) begin
			if (st_reg.chopCnt >= chopDiv - 4'h1)
				st_next.chopCnt = 4'h0;
			else
				st_next.chopCnt = st_reg.chopCnt + 4'h1;
		end
		// The output lags the count by one flop and is high for counts 0 to 3.
		st_next.chopClk = (st_reg.chopCnt < CHOP_HIGH_CNT);

		// The pin comes from a flop, so the event cannot glitch it.
		// RL6 armed interrupt gating
		irqActive = txIrqEvent & st_reg.oc[OC_ARM];
		// RL11 output style select
		if (st_reg.cc[CC_IRQ_OD]) begin
			st_next.irqN = 1'b0;
			st_next.irqOeN = ~irqActive;
		end else begin
			st_next.irqN = ~irqActive;
			st_next.irqOeN = 1'b0;
		end
	end

	// Synchronous reset; srst must be held for at least one edge.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_reg.fsm <= DS_IDLE;
			st_reg.sel <= SEL_OC;
			st_reg.oc <= OC_RESET;
			st_reg.cc <= CC_RESET;
			st_reg.fn <= OF_RESET;
			st_reg.upValid <= 1'b0;
			st_reg.upByte <= 8'h00;
			st_reg.chopCnt <= 4'h0;
			st_reg.chopClk <= 1'b0;
			// The pin stays released until the first edge applies its mode.
			st_reg.irqN <= 1'b1;
			st_reg.irqOeN <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// RL17 answer to far end
	assign link.upValid = st_reg.upValid;
	assign link.upByte = st_reg.upByte;

	// RL2 transmit cutoff
	assign txPathCutoff = st_reg.oc[OC_TX_CUT];
	// RL3 receive cutoff
	assign rxPathCutoff = st_reg.oc[OC_RX_CUT];
	// RL3 B filter off
	assign bFilterDisable = st_reg.oc[OC_RX_CUT];
	// RL4 high-pass disable
	assign txHighpassDisable = st_reg.oc[OC_HPF];
	// RL5 receive loss
	assign rxLossInsert = st_reg.oc[OC_LOSS];
	// RL6 arm bit out
	assign txInterruptArm = st_reg.oc[OC_ARM];
	// RL7 interface loopback
	assign interfaceLoopback = st_reg.oc[OC_ILB];
	// RL8 digital loopback
	assign fullDigitalLoopback = st_reg.oc[OC_FDL];
	// RL9 test tone
	assign rxTestTone = st_reg.oc[OC_TONE];

	// RL15 companding law
	assign muLawSelect = st_reg.fn[OF_MULAW];
	// RL16 coefficient selects
	assign filterCoefSel = st_reg.fn[OF_COEF_HI:0];

	// RL12 chopper output
	assign chopperClk = st_reg.chopClk;
	// RL11 interrupt pin
	assign irqNOut = st_reg.irqN;
	assign irqNOeN = st_reg.irqOeN;

endmodule
`default_nettype wire

// [hw/ccr_ctl_end.sv]
/*
 Controller end: an APB slave takes one register access at a time and plays
 it out as command and data bytes on the monitor channel.
 Assumes the codec answers a read a cycle after the command byte.
*/
`timescale 1ns/10ps
`default_nettype none
module ccr_ctl_end
	import ccr_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        srst,
	ccr_link_if.ctl          link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);

	typedef enum logic [2:0] {
		CS_IDLE = 3'b001,
		CS_DATA = 3'b010,
		CS_WAIT = 3'b100
	} ccr_ctl_fsm_t;

	typedef struct packed {
		ccr_ctl_fsm_t fsm;
		logic [7:0]   wrByte;
		logic         dnValid;
		logic [7:0]   dnByte;
		logic         done;
		logic [7:0]   rdByte;
		logic [31:0]  rdata;
	} ccr_ctl_st_t;

	ccr_ctl_st_t st_reg;
	ccr_ctl_st_t st_next;
	logic        apbWr;
	logic        mapped;
	logic [1:0]  reqSel;

	assign apbWr = psel & penable & pwrite;
	assign mapped = (paddr == APB_CMD) || (paddr == APB_STATUS);
	assign reqSel = pwdata[CMDF_SEL_LO+1:CMDF_SEL_LO];

	always_comb begin
		st_next = st_reg;
		st_next.dnValid = 1'b0;
		if (apbWr && paddr == APB_STATUS && pwdata[STF_DONE])
			st_next.done = 1'b0;
		case (st_reg.fsm)
			CS_IDLE: begin
				// RL1 RL10 RL14 command byte out
				if (apbWr && paddr == APB_CMD && reqSel != SEL_NONE) begin
					st_next.dnValid = 1'b1;
					st_next.dnByte = ccr_cmd_byte(reqSel);
					st_next.dnByte[CMD_READ_BIT] = ~pwdata[CMDF_WRITE];
					// RL13 reserved bits zero
					st_next.wrByte = pwdata[7:0] & ccr_mask(reqSel);
					st_next.fsm = pwdata[CMDF_WRITE] ? CS_DATA : CS_WAIT;
				end
			end
			CS_DATA: begin
				// RL17 data byte follows
				st_next.dnValid = 1'b1;
				st_next.dnByte = st_reg.wrByte;
				st_next.done = 1'b1;
				st_next.fsm = CS_IDLE;
			end
			CS_WAIT: begin
				// RL17 take upstream answer
				if (link.upValid) begin
					st_next.rdByte = link.upByte;
					st_next.done = 1'b1;
					st_next.fsm = CS_IDLE;
				end
			end
			default: begin
				st_next.fsm = CS_IDLE;
			end
		endcase

		// Status is taken in the setup cycle, so prdata leaves a flop.
		if (psel && !penable)
			st_next.rdata = 32'h0000_0000;
		if (psel && !penable && !pwrite && paddr == APB_STATUS) begin
			st_next.rdata[STF_BUSY] = (st_next.fsm != CS_IDLE);
			st_next.rdata[STF_DONE] = st_next.done;
			st_next.rdata[STF_RDATA_LO +: 8] = st_next.rdByte;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_reg.fsm <= CS_IDLE;
			st_reg.wrByte <= 8'h00;
			st_reg.dnValid <= 1'b0;
			st_reg.dnByte <= 8'h00;
			st_reg.done <= 1'b0;
			st_reg.rdByte <= 8'h00;
			st_reg.rdata <= 32'h0000_0000;
		end else begin
			st_reg <= st_next;
		end
	end

	// Every access completes at once, so the bus never stalls on the link.
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	assign prdata = st_reg.rdata;

	assign link.dnValid = st_reg.dnValid;
	assign link.dnByte = st_reg.dnByte;

endmodule
`default_nettype wire

// [tb/ccr_link_sva.sv]
/*
 Checker on the monitor-channel byte link between the two ends.
 Assumes one core_clk domain and a synchronous active-high srst.
*/
`timescale 1ns/10ps
`default_nettype none
module ccr_link_sva
	import ccr_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       srst,
	input wire logic       dnValid,
	input wire logic [7:0] dnByte,
	input wire logic       upValid,
	input wire logic [7:0] upByte
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	// A data byte may look like a command, so track which slot is which.
	logic dataNext_reg;
	logic cmdSlot;
	assign cmdSlot = dnValid && !dataNext_reg;
	always_ff @(posedge core_clk) begin
		if (srst)
			dataNext_reg <= 1'b0;
		else if (dnValid)
			dataNext_reg <= cmdSlot && (dnByte == CMD_OC ||
				dnByte == CMD_CC || dnByte == CMD_OF);
	end

	chk_oc_read_answer: assert property (cmdSlot && dnByte == 8'h71 |=> upValid)
		else $error("operating conditions read not answered");
	chk_cc_read_answer: assert property (cmdSlot && dnByte == 8'h47 |=> upValid)
		else $error("chip configuration read not answered");
	chk_of_read_answer: assert property (cmdSlot && dnByte == 8'h61 |=> upValid)
		else $error("operating functions read not answered");
	chk_up_single: assert property (upValid |=> !upValid)
		else $error("answer strobe longer than one cycle");
	chk_up_cause: assert property (upValid |-> $past(cmdSlot && dnByte[0]))
		else $error("answer without a read command");
	chk_up_hold: assert property (!upValid |-> $stable(upByte))
		else $error("answer byte changed without a strobe");
	chk_wr_data_follows: assert property (cmdSlot && dnByte == 8'h70 |=> dnValid)
		else $error("write command without its data byte");
	chk_cc_rsvd_zero: assert property (cmdSlot && dnByte == 8'h46
		|=> dnValid && dnByte[5:0] == 6'h00)
		else $error("reserved chip configuration bits written as one");
	chk_of_rsvd_zero: assert property (cmdSlot && dnByte == 8'h60
		|=> dnValid && !dnByte[7])
		else $error("reserved operating functions bit written as one");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
/*
 Self-checking bench: APB orders to the controller end, which drives the
 codec end over the link; the codec outputs are judged directly.
 Assumes the 2048 kHz reference is one tick every 49 core_clk cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import ccr_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, refTick = 1'b0, txIrqEvent = 1'b0;
	logic        txPathCutoff, rxPathCutoff, bFilterDisable, txHighpassDisable;
	logic        rxLossInsert, txInterruptArm, interfaceLoopback;
	logic        fullDigitalLoopback, rxTestTone, muLawSelect;
	logic        chopperClk, irqNOut, irqNOeN;
	logic [5:0]  filterCoefSel;
	logic [7:0]  ocOut;
	int          tickCnt = 0, errors = 0, checkCount = 0;

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		tickCnt <= (tickCnt == 48) ? 0 : tickCnt + 1;
		refTick <= (tickCnt == 48);
	end
	assign ocOut = {txPathCutoff, rxPathCutoff, txHighpassDisable, rxLossInsert,
		txInterruptArm, interfaceLoopback, fullDigitalLoopback, rxTestTone};

	ccr_link_if ccr_link_if_inst ();
	ccr_dev_end ccr_dev_end_inst (.core_clk(core_clk), .srst(srst),
		.link(ccr_link_if_inst.dev), .refTick(refTick),
		.txIrqEvent(txIrqEvent), .txPathCutoff(txPathCutoff),
		.rxPathCutoff(rxPathCutoff), .bFilterDisable(bFilterDisable),
		.txHighpassDisable(txHighpassDisable), .rxLossInsert(rxLossInsert),
		.txInterruptArm(txInterruptArm), .interfaceLoopback(interfaceLoopback),
		.fullDigitalLoopback(fullDigitalLoopback), .rxTestTone(rxTestTone),
		.muLawSelect(muLawSelect), .filterCoefSel(filterCoefSel),
		.chopperClk(chopperClk), .irqNOut(irqNOut), .irqNOeN(irqNOeN));
	ccr_ctl_end ccr_ctl_end_inst (.core_clk(core_clk), .srst(srst),
		.link(ccr_link_if_inst.ctl), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	ccr_link_sva ccr_link_sva_inst (.core_clk(core_clk), .srst(srst),
		.dnValid(ccr_link_if_inst.dnValid), .dnByte(ccr_link_if_inst.dnByte),
		.upValid(ccr_link_if_inst.upValid), .upByte(ccr_link_if_inst.upByte));

	task automatic report_and_stop();
		if (errors == 0 && checkCount > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// An idle edge closes every transfer so no signal is set twice at once.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			errors++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic reg_op(input logic [1:0] s, input logic w,
		input logic [7:0] d, output logic [7:0] q);
		logic [31:0] r;
		logic        e;
		int          n;
		n = 0;
		apb(1'b1, APB_CMD, {19'h0, w, 2'h0, s, d}, r, e);
		do begin
			apb(1'b0, APB_STATUS, 32'h0, r, e);
			n++;
		end while (r[STF_BUSY] !== 1'b0 && n < 20);
		if (r[STF_BUSY] !== 1'b0)
			errors++;
		q = r[STF_RDATA_LO +: 8];
	endtask

	task automatic wait_rise(inout int c);
		while (chopperClk === 1'b1 && c < 3000) begin
			@(posedge core_clk);
			c++;
		end
		while (chopperClk !== 1'b1 && c < 3000) begin
			@(posedge core_clk);
			c++;
		end
	endtask

	task automatic t_reset();
		logic [7:0] q;
		reg_op(SEL_OC, 1'b0, 8'h00, q);
		cmp(q, 32'h04);
		reg_op(SEL_CC, 1'b0, 8'h00, q);
		cmp(q, 32'h9A);
		reg_op(SEL_OF, 1'b0, 8'h00, q);
		cmp(q, 32'h00);
		cmp(ocOut, 32'h04);
	endtask

	task automatic t_oc_bits();
		logic [7:0] q;
		for (int i = 0; i < 8; i++) begin
			reg_op(SEL_OC, 1'b1, 8'h01 << i, q);
			cmp(ocOut, 32'h01 << i);
			cmp(bFilterDisable, i == 6);
			cmp(txHighpassDisable, i == 5);
			cmp(rxLossInsert, i == 4);
			cmp(txInterruptArm, i == 3);
			cmp(fullDigitalLoopback, i == 1);
			cmp(rxTestTone, i == 0);
			reg_op(SEL_OC, 1'b0, 8'h00, q);
			cmp(q, 32'h01 << i);
		end
	endtask

	task automatic t_irq_chop();
		logic [7:0] q;
		int         c;
		reg_op(SEL_OC, 1'b1, 8'h08, q);
		txIrqEvent <= 1'b1;
		repeat (3) @(posedge core_clk);
		cmp({irqNOut, irqNOeN}, 32'h0);
		reg_op(SEL_CC, 1'b1, 8'h00, q);
		txIrqEvent <= 1'b0;
		repeat (3) @(posedge core_clk);
		cmp({irqNOut, irqNOeN}, 32'h2);
		reg_op(SEL_CC, 1'b0, 8'h00, q);
		cmp(q, 32'h1A);
		c = 0;
		wait_rise(c);
		c = 0;
		wait_rise(c);
		cmp(c, 32'd392);
		reg_op(SEL_CC, 1'b1, 8'hC0, q);
		cmp({irqNOut, irqNOeN}, 32'h1);
		c = 0;
		wait_rise(c);
		c = 0;
		wait_rise(c);
		cmp(c, 32'd343);
	endtask

	task automatic t_of_bits();
		logic [7:0] q;
		logic [7:0] v [3] = '{8'h7F, 8'h25, 8'h40};
		for (int i = 0; i < 3; i++) begin
			reg_op(SEL_OF, 1'b1, v[i], q);
			cmp({muLawSelect, filterCoefSel}, v[i]);
			reg_op(SEL_OF, 1'b0, 8'h00, q);
			cmp(q, v[i]);
		end
	endtask

	task automatic t_unmapped();
		logic [31:0] r;
		logic        e;
		apb(1'b0, 8'h08, 32'h0, r, e);
		cmp(r, 32'h0);
		cmp(e, 32'h1);
		apb(1'b1, APB_CMD, 32'h0000_0300, r, e);
		apb(1'b0, APB_STATUS, 32'h0, r, e);
		cmp(r[STF_BUSY], 32'h0);
	endtask

	task automatic t_status();
		logic [31:0] r;
		logic        e;
		logic [7:0]  q;
		reg_op(SEL_OF, 1'b0, 8'h00, q);
		apb(1'b0, APB_STATUS, 32'h0, r, e);
		cmp(r, 32'h0000_4002);
		cmp(e, 32'h0);
		apb(1'b1, APB_STATUS, 32'h0000_0002, r, e);
		apb(1'b0, APB_STATUS, 32'h0, r, e);
		cmp(r, 32'h0000_4000);
	endtask

	initial begin
		#600000;
		errors++;
		report_and_stop();
	end

	initial begin
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		t_reset();
		t_oc_bits();
		t_irq_chop();
		t_of_bits();
		t_status();
		t_unmapped();
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		t_reset();
		report_and_stop();
	end
endmodule
`default_nettype wire
